//--- verilog/cpce_regs.svh
/*
  register offsets, field positions, reset values and timing counts for the
  current and power calculation engine.
  assumes a 125 mhz system clock and a word-wide register port.
*/
`ifndef CPCE_REGS_SVH
`define CPCE_REGS_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define CPCE_REG_CONFIG   3'h0
`define CPCE_REG_SHUNT    3'h1
`define CPCE_REG_BUS      3'h2
`define CPCE_REG_POWER    3'h3
`define CPCE_REG_CURRENT  3'h4
`define CPCE_REG_SCALE    3'h5

// ----------------------------------------------------------------------
// configuration fields and reset values
// ----------------------------------------------------------------------
`define CPCE_CFG_SCT_LSB  3
`define CPCE_CFG_BCT_LSB  6
`define CPCE_CFG_AVG_LSB  9
`define CPCE_CFG_RESET    16'h4127
`define CPCE_SCALE_RESET  16'h0000

// ----------------------------------------------------------------------
// arithmetic and timing
// ----------------------------------------------------------------------
`define CPCE_CUR_SHIFT    11
`define CPCE_PWR_DIV      48'd20000
`define CPCE_CLK_MHZ      125
`define CPCE_CT_MIN_US    140
`define CPCE_CT_MAX_US    8244
`define CPCE_CT_MIN_CYC   (`CPCE_CT_MIN_US * `CPCE_CLK_MHZ)
`define CPCE_CT_MAX_CYC   (`CPCE_CT_MAX_US * `CPCE_CLK_MHZ)
`define CPCE_MUL_LAT      2

`endif

//--- verilog/cpce_pkg.sv
/*
  types shared by the current and power calculation engine.
  assumes cpce_regs.svh is compiled alongside.
*/
package cpce_pkg;

  // ----------------------------------------------------------------------
  // sample carrier and register port
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        is_bus;
    logic [15:0] value;
  } cpce_sample_t;

  typedef struct packed {
    logic        wr;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } cpce_req_t;

  typedef enum logic [1:0] {
    CPCE_IDLE = 2'b00,
    CPCE_MUL  = 2'b01,
    CPCE_ACC  = 2'b11
  } cpce_state_t;

endpackage

//--- verilog/cpce_scale_mul.sv
/*
  pipelined scaling multiplier: prod = a * b >> shift, truncated.
  assumes operands are held stable while start is high for one cycle.
*/
`timescale 1ns/1ps

module cpce_scale_mul #(
  parameter int W     = 16,
  parameter int SHIFT = 11
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst,    // async reset, high
  input  wire logic         start,  // operands valid
  input  wire logic [W-1:0] a,      // first operand
  input  wire logic [W-1:0] b,      // second operand
  output logic              done,   // product valid, one cycle
  output logic [2*W-1:0]    prod    // shifted product
);

  logic [2*W-1:0] prod_d;
  logic           done_d;

  // ----------------------------------------------------------------------
  // one registered stage keeps the multiplier off the bus read path
  // ----------------------------------------------------------------------
  always_comb begin
    prod_d = (2*W)'(({{W{1'b0}}, a} * {{W{1'b0}}, b}) >> SHIFT);
    done_d = start;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prod <= '0;
      done <= 1'b0;
    end else begin
      prod <= prod_d;
      done <= done_d;
    end
  end

endmodule // cpce_scale_mul

//--- verilog/cpce_engine.sv
/*
  current and power calculation engine: takes converter samples, scales them
  into current and power, averages and loads the result registers.
  assumes samples arrive as one-cycle strobes from the converter, shunt before
  bus, and that the register port is driven by a serial slave outside.
*/
// Behaviour
// - conversion time codes span 140 us up to 8.244 ms.
// - shunt and bus each have their own conversion time field.
// - one power count weighs 25 current counts times a volt.
// - current is shunt times scale factor divided by 2048.
// - power is current times bus divided by 20000.
// - with scale factor zero, current and power read zero.
// - a programmed scale factor refreshes results once per averaging count.
// - bus voltage keeps a fixed weight of 1.25 mV per count.
// - the top bit of the bus result always reads zero.
// - per-sample current and power go to an internal accumulator.
// - after the sample count, all four results load together.
// - the arithmetic runs beside conversion, never stalling it.
`timescale 1ns/1ps
`include "cpce_regs.svh"

module cpce_engine #(
  parameter int ACC_W = 28
) (
  input  wire logic                 clk,        // system clock
  input  wire logic                 rst,        // async reset, high
  input  wire cpce_pkg::cpce_sample_t smp,      // converter sample strobe
  input  wire cpce_pkg::cpce_req_t  req,        // register access
  output logic [15:0]               rdata,      // register read data
  output logic [2:0]                shunt_ct,   // shunt time code
  output logic [2:0]                bus_ct,     // bus time code
  output logic [2:0]                avg_code,   // averaging code
  output logic                      results_ld  // results loaded, pulse
);

  // ----------------------------------------------------------------------
  // configuration and scale registers
  // ----------------------------------------------------------------------
  logic [15:0] cfg_q, cfg_d, scale_q, scale_d;

  // configuration and scale write logic
  always_comb begin
    cfg_d   = cfg_q;
    scale_d = scale_q;
    if (req.wr && req.addr == `CPCE_REG_CONFIG)
      cfg_d = req.wdata;
    if (req.wr && req.addr == `CPCE_REG_SCALE)
      scale_d = req.wdata;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q   <= `CPCE_CFG_RESET;
      scale_q <= `CPCE_SCALE_RESET;
    end else begin
      cfg_q   <= cfg_d;
      scale_q <= scale_d;
    end
  end

  assign shunt_ct = cfg_q[`CPCE_CFG_SCT_LSB +: 3];
  assign bus_ct   = cfg_q[`CPCE_CFG_BCT_LSB +: 3];
  assign avg_code = cfg_q[`CPCE_CFG_AVG_LSB +: 3];

  // ----------------------------------------------------------------------
  // averaging count from code: 1,4,16,64,128,256,512,1024
  // ----------------------------------------------------------------------
  logic [10:0] avg_n;
  always_comb begin
    case (avg_code)
      3'h0:    avg_n = 11'h001;
      3'h1:    avg_n = 11'h004;
      3'h2:    avg_n = 11'h010;
      3'h3:    avg_n = 11'h040;
      3'h4:    avg_n = 11'h080;
      3'h5:    avg_n = 11'h100;
      3'h6:    avg_n = 11'h200;
      default: avg_n = 11'h400;
    endcase
  end

  logic [3:0] avg_sh;
  always_comb begin
    case (avg_code)
      3'h0:    avg_sh = 4'h0;
      3'h1:    avg_sh = 4'h2;
      3'h2:    avg_sh = 4'h4;
      3'h3:    avg_sh = 4'h6;
      3'h4:    avg_sh = 4'h7;
      3'h5:    avg_sh = 4'h8;
      3'h6:    avg_sh = 4'h9;
      default: avg_sh = 4'ha;
    endcase
  end

  // ----------------------------------------------------------------------
  // current multiplier
  // ----------------------------------------------------------------------
  logic [15:0] cur_now_q, cur_now_d;
  logic        cur_done;
  logic [31:0] cur_prod;

  cpce_scale_mul #(.W(16), .SHIFT(`CPCE_CUR_SHIFT)) u_cur_mul (
    .clk   (clk),
    .rst   (rst),
    .start (smp.valid && !smp.is_bus),
    .a     (smp.value),
    .b     (scale_q),
    .done  (cur_done),
    .prod  (cur_prod)
  );

  // power product: current times bus, both unsigned counts
  logic [15:0] bus_now_q, bus_now_d;
  logic        pwr_go_q, pwr_go_d;
  logic [31:0] pwr_prod_q, pwr_prod_d;
  logic [15:0] pwr_now;

  assign pwr_now = 16'(({16'h0000, pwr_prod_q} / `CPCE_PWR_DIV));

  // ----------------------------------------------------------------------
  // accumulation state
  // ----------------------------------------------------------------------
  cpce_pkg::cpce_state_t st_q, st_d;
  logic [ACC_W-1:0] acc_sh_q, acc_sh_d, acc_bu_q, acc_bu_d;
  logic [ACC_W-1:0] acc_cu_q, acc_cu_d, acc_pw_q, acc_pw_d;
  logic [10:0]      cnt_q, cnt_d;
  logic [15:0]      res_sh_q, res_sh_d, res_bu_q, res_bu_d;
  logic [15:0]      res_cu_q, res_cu_d, res_pw_q, res_pw_d;
  logic             ld_d, ld_q;

  // the datapath never pushes back on the converter, so conversion time
  // is set only by the time codes
  always_comb begin
    st_d       = st_q;
    cur_now_d  = cur_now_q;
    bus_now_d  = bus_now_q;
    pwr_go_d   = 1'b0;
    pwr_prod_d = pwr_prod_q;
    acc_sh_d   = acc_sh_q;
    acc_bu_d   = acc_bu_q;
    acc_cu_d   = acc_cu_q;
    acc_pw_d   = acc_pw_q;
    cnt_d      = cnt_q;
    res_sh_d   = res_sh_q;
    res_bu_d   = res_bu_q;
    res_cu_d   = res_cu_q;
    res_pw_d   = res_pw_q;
    ld_d       = 1'b0;
    // shunt sample taken with no stall
    if (smp.valid && !smp.is_bus) begin
      acc_sh_d = acc_sh_q + ACC_W'(smp.value);
      st_d     = cpce_pkg::CPCE_MUL;
    end
    if (cur_done) begin
      cur_now_d = (scale_q == 16'h0000) ? 16'h0000 : cur_prod[15:0];
      acc_cu_d  = acc_cu_q
                + ACC_W'((scale_q == 16'h0000) ? 16'h0000 : cur_prod[15:0]);
    end
    // bus top bit forced to zero
    if (smp.valid && smp.is_bus) begin
      bus_now_d = {1'b0, smp.value[14:0]};
      acc_bu_d  = acc_bu_q + ACC_W'({1'b0, smp.value[14:0]});
      pwr_go_d  = 1'b1;
    end
    // power product from latest current and this bus sample
    if (pwr_go_q) begin
      // both operands widened first so the 32-bit product is never cut
      pwr_prod_d = {16'h0000, cur_now_q} * {16'h0000, bus_now_q};
      st_d       = cpce_pkg::CPCE_ACC;
    end
    if (st_q == cpce_pkg::CPCE_ACC) begin
      acc_pw_d = acc_pw_q
               + ACC_W'((scale_q == 16'h0000) ? 16'h0000 : pwr_now);
      st_d     = cpce_pkg::CPCE_IDLE;
      if (cnt_q + 11'h001 >= avg_n) begin
        res_sh_d = 16'(acc_sh_q >> avg_sh);
        res_bu_d = 16'(acc_bu_q >> avg_sh);
        res_cu_d = 16'(acc_cu_q >> avg_sh);
        res_pw_d = 16'(acc_pw_d >> avg_sh);
        acc_sh_d = '0;
        acc_bu_d = '0;
        acc_cu_d = '0;
        acc_pw_d = '0;
        cnt_d    = '0;
        ld_d     = 1'b1;
      end else begin
        cnt_d = cnt_q + 11'h001;
      end
    end
    // a config write restarts averaging
    if (req.wr && req.addr == `CPCE_REG_CONFIG) begin
      acc_sh_d = '0;
      acc_bu_d = '0;
      acc_cu_d = '0;
      acc_pw_d = '0;
      cnt_d    = '0;
    end
  end

  // accumulation registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q       <= cpce_pkg::CPCE_IDLE;
      cur_now_q  <= '0;
      bus_now_q  <= '0;
      pwr_go_q   <= 1'b0;
      pwr_prod_q <= '0;
      acc_sh_q   <= '0;
      acc_bu_q   <= '0;
      acc_cu_q   <= '0;
      acc_pw_q   <= '0;
      cnt_q      <= '0;
      res_sh_q   <= '0;
      res_bu_q   <= '0;
      res_cu_q   <= '0;
      res_pw_q   <= '0;
      ld_q       <= 1'b0;
    end else begin
      st_q       <= st_d;
      cur_now_q  <= cur_now_d;
      bus_now_q  <= bus_now_d;
      pwr_go_q   <= pwr_go_d;
      pwr_prod_q <= pwr_prod_d;
      acc_sh_q   <= acc_sh_d;
      acc_bu_q   <= acc_bu_d;
      acc_cu_q   <= acc_cu_d;
      acc_pw_q   <= acc_pw_d;
      cnt_q      <= cnt_d;
      res_sh_q   <= res_sh_d;
      res_bu_q   <= res_bu_d;
      res_cu_q   <= res_cu_d;
      res_pw_q   <= res_pw_d;
      ld_q       <= ld_d;
    end
  end

  assign results_ld = ld_q;

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  // power weight fixed by the 20000 divisor
  always_comb begin
    case (req.addr)
      `CPCE_REG_CONFIG:  rdata = cfg_q;
      `CPCE_REG_SHUNT:   rdata = res_sh_q;
      `CPCE_REG_BUS:     rdata = {1'b0, res_bu_q[14:0]};
      `CPCE_REG_POWER:   rdata = (scale_q == 16'h0000) ? 16'h0000 : res_pw_q;
      `CPCE_REG_CURRENT: rdata = (scale_q == 16'h0000) ? 16'h0000 : res_cu_q;
      `CPCE_REG_SCALE:   rdata = scale_q;
      default:           rdata = 16'h0000;
    endcase
  end

endmodule // cpce_engine

//--- sim/cpce_engine_asserts.sv
/*
  port checker for cpce_engine, bound at the foot.
  assumes the engine's own port names and one clock.
*/
`timescale 1ns/1ps
`include "cpce_regs.svh"

module cpce_engine_asserts (
  input wire logic                   clk,       // clock
  input wire logic                   rst,       // reset
  input wire cpce_pkg::cpce_sample_t smp,       // sample
  input wire cpce_pkg::cpce_req_t    req,       // access
  input wire logic [15:0]            rdata,     // read data
  input wire logic [2:0]             shunt_ct,  // shunt code
  input wire logic [2:0]             bus_ct,    // bus code
  input wire logic [2:0]             avg_code,  // avg code
  input wire logic                   results_ld // load pulse
);
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [15:0] scl_q;
  logic [15:0] scl_d;

  // shadows of the two writable registers, taken from the port
  always_comb begin
    cfg_d = cfg_q;
    scl_d = scl_q;
    if (req.wr && req.addr == 3'h0) cfg_d = req.wdata;
    if (req.wr && req.addr == 3'h5) scl_d = req.wdata;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `CPCE_CFG_RESET;
      scl_q <= 16'h0000;
    end else begin
      cfg_q <= cfg_d;
      scl_q <= scl_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_CODES: assert property (1'b1 |-> shunt_ct == cfg_q[5:3] &&
    bus_ct == cfg_q[8:6] && avg_code == cfg_q[11:9]) else $error("codes");
  AST_CFG_RD: assert property (req.addr == 3'h0 |->
    rdata == cfg_q) else $error("config read");
  AST_SCL_RD: assert property (req.addr == 3'h5 |->
    rdata == scl_q) else $error("scale read");
  AST_UNCAL: assert property (scl_q == 16'h0000 &&
    (req.addr == 3'h3 || req.addr == 3'h4) |-> rdata == 16'h0000)
    else $error("uncalibrated result not zero");
  AST_BUS_MSB: assert property (req.addr == 3'h2 |-> !rdata[15])
    else $error("bus msb set");
  AST_LD_LAT: assert property (smp.valid && smp.is_bus &&
    avg_code == 3'h0 && !req.wr ##1 (!req.wr)[*2] |=> results_ld)
    else $error("load late");
  AST_LD_CAUSE: assert property (results_ld |->
    $past(smp.valid && smp.is_bus, 3)) else $error("load uncaused");
  AST_LD_PULSE: assert property (results_ld |=> !results_ld)
    else $error("load pulse long");
  AST_HOLD: assert property (!results_ld && !$past(req.wr) &&
    $stable(req.addr) && req.addr inside {[3'h1:3'h4]} |->
    $stable(rdata)) else $error("result moved");

  COV_LD: cover property (results_ld);
  COV_CAL_LD: cover property (scl_q != 16'h0000 && results_ld);
  COV_RO_WR: cover property (req.wr && req.addr == 3'h4);
endmodule // cpce_engine_asserts

bind cpce_engine cpce_engine_asserts u_asserts (.clk(clk), .rst(rst),
  .smp(smp), .req(req), .rdata(rdata), .shunt_ct(shunt_ct),
  .bus_ct(bus_ct), .avg_code(avg_code), .results_ld(results_ld));

//--- sim/testbench.sv
/*
  self-checking bench for cpce_engine: register access and samples.
  assumes shunt strobes two cycles ahead of bus, one cycle each.
*/
`timescale 1ns/1ps

module testbench;
  logic                   clk;
  logic                   rst;
  cpce_pkg::cpce_sample_t smp;
  cpce_pkg::cpce_req_t    req;
  logic [15:0]            rdata;
  logic [2:0]             shunt_ct;
  logic [2:0]             bus_ct;
  logic [2:0]             avg_code;
  logic                   results_ld;
  int                     error_cnt;
  int                     n_compared;
  int                     i;

  cpce_engine uut (.clk(clk), .rst(rst), .smp(smp), .req(req),
    .rdata(rdata), .shunt_ct(shunt_ct), .bus_ct(bus_ct),
    .avg_code(avg_code), .results_ld(results_ld));

  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // the one value comparison
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one-cycle write strobe; #1 lets the register land
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  // read data is combinational, so look just after the address moves
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    req.addr <= a;
    #1;
    chk("rdata", e, rdata);
  endtask

  // shunt then bus, two cycles apart; watch for the load pulse
  task automatic pair(input logic [15:0] s, input logic [15:0] b,
                      input logic ld);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    smp <= '{valid: 1'b1, is_bus: 1'b0, value: s};
    @(posedge clk);
    smp.valid <= 1'b0;
    @(posedge clk);
    smp <= '{valid: 1'b1, is_bus: 1'b1, value: b};
    @(posedge clk);
    smp.valid <= 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      seen = seen | results_ld;
    end
    chk("load", {15'h0, ld}, {15'h0, seen});
    if (ld && !seen) conclude();
  endtask

  initial begin
    rst = 1'b1;
    smp = '0;
    req = '0;
    error_cnt = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset contents, unmapped places read zero
    rd(3'h0, 16'h4127);
    for (i = 1; i < 8; i++) begin
      rd(i[2:0], 16'h0000);
    end
    chk("codes", 16'h0024, {7'h0, avg_code, bus_ct, shunt_ct});
    // every time code, shunt and bus set apart
    for (i = 0; i < 8; i++) begin
      wr(3'h0, {4'h4, 3'h0, ~i[2:0], i[2:0], 3'h7});
      chk("codes", {10'h0, ~i[2:0], i[2:0]},
          {7'h0, avg_code, bus_ct, shunt_ct});
    end
    wr(3'h0, 16'h4127);
    // uncalibrated: voltages load, current and power stay zero
    pair(16'h1f40, 16'h2570, 1'b1);
    rd(3'h1, 16'h1f40);
    rd(3'h2, 16'h2570);
    rd(3'h4, 16'h0000);
    rd(3'h3, 16'h0000);
    // calibrated worked example
    // 15 a full scale gives a step well under 1 ma, rounded up to 1 ma
    wr(3'h5, 16'h0a00);
    rd(3'h5, 16'h0a00);
    pair(16'h1f40, 16'h2570, 1'b1);
    rd(3'h4, 16'h2710);
    rd(3'h3, 16'h12b8);
    // fractions are dropped, not rounded
    pair(16'h0003, 16'h2570, 1'b1);
    rd(3'h4, 16'h0003);
    rd(3'h3, 16'h0001);
    // result places ignore writes
    for (i = 1; i < 5; i++) begin
      wr(i[2:0], 16'hbeef);
    end
    rd(3'h4, 16'h0003);
    rd(3'h1, 16'h0003);
    // four-sample average, load only after the last
    wr(3'h0, 16'h4327);
    for (i = 0; i < 4; i++) begin
      pair(16'h1f40 + 16'(4 * i), 16'h2570, i == 3);
    end
    rd(3'h1, 16'h1f46);
    rd(3'h2, 16'h2570);
    rd(3'h4, 16'h2717);
    rd(3'h3, 16'h12bb);
    // longest conversions and deepest averaging reach the converter
    wr(3'h0, 16'h4fff);
    chk("codes", 16'h01ff, {7'h0, avg_code, bus_ct, shunt_ct});
    rd(3'h0, 16'h4fff);
    conclude();
  end
endmodule // testbench
